// ---- bench/tcp_ext_model.sv ----
// Far-side model: remapped external timer clock pins and gate pins.
// Assumes bench requests on sys_clk; clock pins stay low outside bursts.
`timescale 1ns/1ps
module tcp_ext_model (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [1:0] pin_idx,
  input  wire logic [3:0] edges,
  input  wire logic [3:0] gap,
  input  wire logic [3:0] gate_lvl,
  output logic      [3:0] ext_clk,
  output logic      [3:0] gate,
  output logic            busy
);
  initial ext_clk = 4'h0;
  initial busy = 1'b0;
  // Burst of rising edges on one routed pin, each level held gap cycles
  always @(posedge go) begin
    busy <= 1'b1;
    repeat (edges) begin
      repeat (gap) @(posedge sys_clk);
      ext_clk[pin_idx] <= 1'b1;
      repeat (gap) @(posedge sys_clk);
      ext_clk[pin_idx] <= 1'b0;
    end
    busy <= 1'b0;
  end
  assign gate = gate_lvl;
endmodule : tcp_ext_model

// ---- bench/tcp_timer_pairs_props.sv ----
// Checker for the timer pairs: bus handshake, sticky flags, ADC trigger.
// Assumes it is bound to tcp_timer_pairs and sees only that module's ports.
`timescale 1ns/1ps
module tcp_timer_pairs_props (
  input wire logic                      sys_clk,
  input wire logic                      rst_b,
  input wire logic                      cyc_i,
  input wire logic                      stb_i,
  input wire logic                      we_i,
  input wire logic [tcp_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0]                sel_i,
  input wire logic [tcp_pkg::DAT_W-1:0] dat_i,
  input wire logic [tcp_pkg::DAT_W-1:0] dat_o,
  input wire logic                      ack_o,
  input wire logic [tcp_pkg::NTMR-1:0]  external_timer_clock_pin,
  input wire logic [tcp_pkg::NTMR-1:0]  gate_pin,
  input wire logic                      cpu_idle,
  input wire logic                      cpu_sleep,
  input wire logic [tcp_pkg::NTMR-1:0]  timer_flag,
  input wire logic                      adc_trigger
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // A bus request still waiting for its answer
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // The write strobe that reaches the flag register
  sequence flag_write;
    ack_o && we_i && adr_i[5:2] == 4'hc;
  endsequence
  bus_answer_a: assert property (bus_req |=> ack_o) else $error("request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> cyc_i && stb_i) else $error("ack without request");
  read_width_a: assert property (dat_o[31:16] == 16'h0)
    else $error("read data above bit 15");
  adc_pulse_a: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger too long");
  adc_source_a: assert property (adc_trigger |-> timer_flag[1] || $past(timer_flag[1]))
    else $error("trigger without upper flag of pair a");
  flag_sticky_a: assert property ((|(~timer_flag & $past(timer_flag)))
    |-> $past(ack_o && we_i && adr_i[5:2] == 4'hc))
    else $error("flag dropped without a clear");
  reset_clear_a: assert property ($rose(rst_b)
    |-> timer_flag == 4'h0 && !adc_trigger && !ack_o)
    else $error("outputs not clear after reset");
  cover_clear_c: cover property (flag_write);
endmodule : tcp_timer_pairs_props

bind tcp_timer_pairs tcp_timer_pairs_props tcp_timer_pairs_props_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .external_timer_clock_pin(external_timer_clock_pin), .gate_pin(gate_pin),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .timer_flag(timer_flag),
  .adc_trigger(adc_trigger));

// ---- bench/test_tcp_timer_pairs.sv ----
// Self-checking bench for the timer pairs: registers, prescale, join, pins.
// Assumes the package, design, far-side model and checker compile first.
`timescale 1ns/1ps
module test_tcp_timer_pairs;
  logic        sys_clk = 1'b0, rst_b = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        go = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0, ack_o, adc_trigger, busy;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h3, edges = 4'h0, gap = 4'h2, gate_lvl = 4'h0;
  logic [3:0]  ext_clk, gate, timer_flag;
  logic [1:0]  pin_idx = 2'h2;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [15:0] v;
  int          err_count = 0, num_checks = 0, adc_seen = 0, c, p, ex, lo, stop;
  tcp_timer_pairs tcp_timer_pairs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .external_timer_clock_pin(ext_clk), .gate_pin(gate), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .timer_flag(timer_flag), .adc_trigger(adc_trigger));
  tcp_ext_model tcp_ext_model_inst (.sys_clk(sys_clk), .go(go), .pin_idx(pin_idx),
    .edges(edges), .gap(gap), .gate_lvl(gate_lvl), .ext_clk(ext_clk), .gate(gate), .busy(busy));
  // ****************************************
  // Clock, trigger monitor, watchdog
  // ****************************************
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (adc_trigger === 1'b1) adc_seen++;
  initial begin
    #400_000; // About 40,000 cycles, over twice the longest expected run
    err_count++;
    summarize();
  end
  // ****************************************
  // Tasks and functions
  // ****************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, d};
    do begin
      @(posedge sys_clk);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask : wb
  task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check_val
  task automatic check_win(input string what, input int l, input int h, input int g);
    num_checks++;
    if (g < l || g > h) begin
      err_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, l, h, g);
    end
  endtask : check_win
  task automatic wait_flag(input int i, input int lim);
    for (c = 0; c < lim && timer_flag[i] !== 1'b1; c++) @(posedge sys_clk);
  endtask : wait_flag
  task automatic burst(input logic [3:0] e);
    edges <= e;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int k = 0; k < 400 && busy === 1'b1; k++) @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
  endtask : burst
  function automatic int exp_cycles(input int ps, input int ticks);
    int div[4] = '{1, 8, 64, 256};
    return ticks * 2 * div[ps];
  endfunction : exp_cycles
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h11758644));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    wb(1'b1, 8'h34, 16'hffff);
    for (int a = 0; a < 14; a++) begin
      wb(1'b0, 8'(a * 4), 16'h0);
      check_val("reset value", 32'h0, rd);
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom) & 16'h7ff7;
      wb(1'b1, 8'(i * 4), v);
      wb(1'b0, 8'(i * 4), 16'h0);
      ex = (i % 2 == 0) ? tcp_pkg::CTRL_MASK_LOWER : tcp_pkg::CTRL_MASK_UPPER;
      check_val("control", 32'(v & 16'(ex)), rd);
      wb(1'b1, 8'(i * 4), 16'h0);
      for (int g = 1; g < 3; g++) begin
        v = 16'($urandom);
        wb(1'b1, 8'(g * 16 + i * 4), v);
        wb(1'b0, 8'(g * 16 + i * 4), 16'h0);
        check_val("period or count", 32'(v), rd);
      end
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      for (int ps = 0; ps < 4; ps++) begin
        p = 2 + $urandom % 4;
        cpu_idle <= 1'($urandom);
        v = 16'($urandom) & 16'h2000;
        wb(1'b1, 8'(32 + i * 4), 16'h0);
        wb(1'b1, 8'(16 + i * 4), 16'(p));
        wb(1'b1, 8'h30, 16'hf);
        adc_seen = 0;
        wb(1'b1, 8'(i * 4), 16'h8000 | v | 16'(ps << 4));
        ex = exp_cycles(ps, p + 1);
        stop = (cpu_idle === 1'b1 && v != 16'h0);
        wait_flag(i, ex + 10);
        if (stop) check_win("idle halt cycles", ex + 10, ex + 10, c);
        else check_win("split flag cycles", ex - 4, ex + 3, c);
        check_val("split flags", stop ? 32'h0 : 32'(4'b1 << i), 32'(timer_flag));
        wb(1'b1, 8'(i * 4), 16'h0);
        check_val("split trigger", 32'(i == 1 && !stop), 32'(adc_seen != 0));
      end
    end
    $display("test split done");
    wb(1'b1, 8'h28, 16'h0);
    wb(1'b1, 8'h18, 16'h3);
    wb(1'b1, 8'h30, 16'hf);
    cpu_sleep <= 1'b1;
    gap <= 4'(2 + $urandom % 6);
    wb(1'b1, 8'h08, 16'h8002);
    burst(4'h3);
    check_val("flag after three edges", 32'h0, 32'(timer_flag[2]));
    burst(4'h1);
    check_val("flag after four edges", 32'h1, 32'(timer_flag[2]));
    cpu_sleep <= 1'b0;
    wb(1'b1, 8'h08, 16'h0);
    $display("test external done");
    wb(1'b1, 8'h20, 16'h0);
    wb(1'b1, 8'h10, 16'h2);
    wb(1'b1, 8'h30, 16'hf);
    wb(1'b1, 8'h00, 16'h8040);
    repeat (40) @(posedge sys_clk);
    wb(1'b0, 8'h20, 16'h0);
    check_val("gated count", 32'h0, rd);
    gate_lvl <= 4'h1;
    repeat (3) @(posedge sys_clk);
    gate_lvl <= 4'h0;
    repeat (6) @(posedge sys_clk);
    check_val("gate fall flag", 32'h1, 32'(timer_flag[0]));
    wb(1'b1, 8'h00, 16'h0);
    $display("test gate done");
    for (int pr = 0; pr < 2; pr++) begin
      lo = pr * 8;
      wb(1'b1, 8'h30, 16'hf);
      wb(1'b1, 8'(32 + lo), 16'hfff0);
      wb(1'b1, 8'(36 + lo), 16'h0);
      wb(1'b1, 8'(16 + lo), 16'h0002);
      wb(1'b1, 8'(20 + lo), 16'h0001);
      wb(1'b1, 8'(lo), 16'h0008);
      wb(1'b1, 8'(4 + lo), 16'h8032);
      adc_seen = 0;
      wb(1'b1, 8'(lo), 16'h8008);
      wait_flag(pr * 2 + 1, 200);
      check_win("joined flag cycles", 34, 41, c);
      check_val("joined flags", 32'(4'b0010 << (pr * 2)), 32'(timer_flag));
      wb(1'b1, 8'(lo), 16'h0);
      check_val("joined trigger", 32'(pr == 0), 32'(adc_seen != 0));
    end
    $display("test joined done");
    summarize();
  end
endmodule : test_tcp_timer_pairs

// ---- design/tcp_timer_pairs.sv ----
// Two cascadable pairs of 16-bit timers behind a classic Wishbone slave.
// Assumes sys_clk is the oscillator clock; external pins and gates are
// synchronous to it. Timer 0/1 form pair a, timers 2/3 pair b.
// Assumes software sets mode, prescale, source and period before the run bit.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps

module tcp_timer_pairs (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [tcp_pkg::ADR_W-1:0]  adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [tcp_pkg::DAT_W-1:0]  dat_i,
  output logic      [tcp_pkg::DAT_W-1:0]  dat_o,
  output logic                            ack_o,
  input  wire logic [tcp_pkg::NTMR-1:0]   external_timer_clock_pin,
  input  wire logic [tcp_pkg::NTMR-1:0]   gate_pin,
  input  wire logic                       cpu_idle,
  input  wire logic                       cpu_sleep,
  output logic      [tcp_pkg::NTMR-1:0]   timer_flag,
  output logic                            adc_trigger
);

  // ********************************************
  // Register state
  // ********************************************
  // Per-timer words, ordered lower a, upper a, lower b, upper b
  tcp_pkg::tcp_ctrl_t                     ctrl [tcp_pkg::NTMR];
  logic [tcp_pkg::REG_W-1:0]              per  [tcp_pkg::NTMR];
  logic [tcp_pkg::REG_W-1:0]              cnt  [tcp_pkg::NTMR];
  logic [tcp_pkg::REG_W-1:0]              next_cnt [tcp_pkg::NTMR];
  logic [7:0]                             pre_cnt  [tcp_pkg::NTMR];
  logic [7:0]                             pre_lim  [tcp_pkg::NTMR];
  logic [tcp_pkg::NTMR-1:0]               ext_prev;
  logic [tcp_pkg::NTMR-1:0]               gate_prev;
  logic [tcp_pkg::NTMR-1:0]               run;
  logic [tcp_pkg::NTMR-1:0]               src_pulse;
  logic [tcp_pkg::NTMR-1:0]               tick;
  logic [tcp_pkg::NTMR-1:0]               gate_fall;
  logic [tcp_pkg::NTMR-1:0]               event_set;
  logic [tcp_pkg::NTMR-1:0]               cnt_wr;
  logic                                   inst_phase;
  logic                                   next_adc;

  // ********************************************
  // Bus decode
  // ********************************************
  logic                                   req;
  logic                                   wr_take;
  logic [3:0]                             idx;
  logic [tcp_pkg::REG_W-1:0]              wr_word;
  logic [tcp_pkg::REG_W-1:0]              rd_word;

  // Request presented, and write taken on the edge that sees ack.
  // Acting on a write only while ack_o is high puts the update on the
  // very edge at which the master samples the answer, so a request that
  // is withdrawn early leaves no half-written register behind.
  assign req     = cyc_i & stb_i;
  assign wr_take = req & we_i & ack_o;
  assign idx     = adr_i[tcp_pkg::IDX_HI:tcp_pkg::IDX_LO];

  // Byte-lane merge of the low 16 bits
  // Lanes 2 and 3 carry no register bits and are ignored
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  lanes);
    logic [15:0] r;
    r = old_v;
    if (lanes[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (lanes[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : lane_merge

  // Only the low half of the write data reaches the 16-bit registers
  assign wr_word = dat_i[tcp_pkg::REG_W-1:0];

  // Read multiplexer; unmapped words read as zero
  // The flag word shows the live sticky bits; reading never clears them
  // Only bits 15:0 exist; the upper half of the bus reads zero
  always_comb begin
    rd_word = tcp_pkg::REG_RESET;
    case (idx)
      4'h0, 4'h1, 4'h2, 4'h3: rd_word = ctrl[idx[1:0]];
      4'h4, 4'h5, 4'h6, 4'h7: rd_word = per[idx[1:0]];
      4'h8, 4'h9, 4'ha, 4'hb: rd_word = cnt[idx[1:0]];
      tcp_pkg::IDX_FLAGS:     rd_word = {12'h000, timer_flag};
      default:                rd_word = tcp_pkg::REG_RESET;
    endcase
  end

  // Acknowledge one cycle after the request, drop it the cycle after
  // The ~ack_o term forces a gap, so one request yields exactly one ack
  // Unmapped addresses are answered too, so the master never stalls
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  // Read data captured with the acknowledge
  // Loaded on the edge that raises ack, so it stands while ack is high
  // and holds afterwards until the next request, read or write, is captured
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dat_o <= '0;
    end else if (req & ~ack_o) begin
      dat_o <= {16'h0000, rd_word};
    end
  end

  // ********************************************
  // Control and period registers
  // ********************************************
  // Upper timers have no join bit; only lower control can join a pair
  // Upper control stays writable while joined; the pair logic simply does
  // not look at it, so software may prepare split operation in advance
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < tcp_pkg::NTMR; i++) begin
        ctrl[i] <= tcp_pkg::REG_RESET;
        per[i]  <= tcp_pkg::REG_RESET;
      end
    end else if (wr_take) begin
      for (int i = 0; i < tcp_pkg::NTMR; i++) begin
        if (idx == tcp_pkg::IDX_CTRL_BASE + 4'(i)) begin
          ctrl[i] <= lane_merge(ctrl[i], wr_word, sel_i[1:0])
                     & ((i % 2 == 0) ? tcp_pkg::CTRL_MASK_LOWER
                                     : tcp_pkg::CTRL_MASK_UPPER);
        end
        if (idx == tcp_pkg::IDX_PER_BASE + 4'(i)) begin
          per[i] <= lane_merge(per[i], wr_word, sel_i[1:0]);
        end
      end
    end
  end

  // ********************************************
  // Clock sources and prescalers
  // ********************************************
  // Instruction clock runs at half the oscillator rate
  // One free-running phase bit is shared by every internal source, so
  // timers started together stay in step with each other
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      inst_phase <= 1'b0;
    end else begin
      inst_phase <= ~inst_phase;
    end
  end

  // Previous pin levels for edge detection
  // Reset to the pins' idle low level, so leaving reset makes no false edge
  // Pins are taken as synchronous, so one register stage suffices
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev  <= '0;
      gate_prev <= '0;
    end else begin
      ext_prev  <= external_timer_clock_pin;
      gate_prev <= gate_pin;
    end
  end

  // Per-timer source select, gating and prescale
  for (genvar i = 0; i < tcp_pkg::NTMR; i++) begin : g_src
    // Run while on; idle halts only when asked, sleep stops Fosc/2 only
    // Stopping clears the prescaler but keeps the count for software
    assign run[i] = ctrl[i].timer_run_enable
                    & ~(cpu_idle & ctrl[i].idle_halt);

    // External source counts rising pin edges whatever the gate does;
    // the internal source is masked by sleep and, when enabled, by the gate
    always_comb begin
      if (ctrl[i].clock_source_select) begin
        src_pulse[i] = external_timer_clock_pin[i] & ~ext_prev[i];
      end else begin
        src_pulse[i] = inst_phase & ~cpu_sleep
                       & (~ctrl[i].gated_accumulation_enable | gate_pin[i]);
      end
    end

    // Divide ratio decode
    // The terminal count is one less than the ratio, as the count starts at 0
    always_comb begin
      case (ctrl[i].prescale_ratio_field)
        tcp_pkg::PS_256: pre_lim[i] = tcp_pkg::PS_LIM_256;
        tcp_pkg::PS_64:  pre_lim[i] = tcp_pkg::PS_LIM_64;
        tcp_pkg::PS_8:   pre_lim[i] = tcp_pkg::PS_LIM_8;
        tcp_pkg::PS_1:   pre_lim[i] = tcp_pkg::PS_LIM_1;
        default:         pre_lim[i] = tcp_pkg::PS_LIM_1;
      endcase
    end

    // Every tick is a sys_clk-synchronous pulse: no asynchronous counting
    // A tick needs the source pulse that completes the prescale count
    assign tick[i] = run[i] & src_pulse[i] & (pre_cnt[i] == pre_lim[i]);

    // Falling gate edge ends an accumulation period
    // It raises the flag even without a match, as a gated measurement
    // is complete on that edge
    assign gate_fall[i] = run[i] & ctrl[i].gated_accumulation_enable
                          & ~ctrl[i].clock_source_select
                          & gate_prev[i] & ~gate_pin[i];

    // Prescale counter clears while stopped
    // Clearing it keeps the first period after a start a full period long;
    // it advances on source pulses only, never on every sys_clk edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        pre_cnt[i] <= 8'h00;
      end else if (!run[i]) begin
        pre_cnt[i] <= 8'h00;
      end else if (src_pulse[i]) begin
        pre_cnt[i] <= (pre_cnt[i] == pre_lim[i]) ? 8'h00 : pre_cnt[i] + 8'h01;
      end
    end
  end

  // ********************************************
  // Pair counting
  // ********************************************
  for (genvar p = 0; p < tcp_pkg::NPAIR; p++) begin : g_pair
    localparam int LO = 2 * p;
    localparam int HI = 2 * p + 1;
    logic        joined;
    logic [31:0] cat_cnt;
    logic [31:0] cat_per;
    logic [31:0] cat_next;

    // The join bit lives only in the lower control word; the upper timer
    // keeps its own count and period registers as the high halves
    assign joined  = ctrl[LO].pair_join_select;
    assign cat_cnt = {cnt[HI], cnt[LO]};
    assign cat_per = {per[HI], per[LO]};
    // Match is judged before the add, and the count wraps to zero on it
    assign cat_next = (cat_cnt == cat_per) ? 32'h0000_0000 : cat_cnt + 32'h1;

    always_comb begin
      next_cnt[LO]  = cnt[LO];
      next_cnt[HI]  = cnt[HI];
      event_set[LO] = 1'b0;
      event_set[HI] = 1'b0;
      if (joined) begin
        // Lower control, clock and gate drive the 32-bit count
        // The carry into the high word is part of one 32-bit add
        if (tick[LO]) begin
          {next_cnt[HI], next_cnt[LO]} = cat_next;
          event_set[HI] = (cat_cnt == cat_per);
        end
        event_set[HI] = event_set[HI] | gate_fall[LO];
      end else begin
        // Two independent 16-bit timers, each on its own period and clock
        if (tick[LO]) begin
          next_cnt[LO]  = (cnt[LO] == per[LO]) ? 16'h0000 : cnt[LO] + 16'h0001;
          event_set[LO] = (cnt[LO] == per[LO]);
        end
        if (tick[HI]) begin
          next_cnt[HI]  = (cnt[HI] == per[HI]) ? 16'h0000 : cnt[HI] + 16'h0001;
          event_set[HI] = (cnt[HI] == per[HI]);
        end
        // A falling gate edge flags its own timer only
        event_set[LO] = event_set[LO] | gate_fall[LO];
        event_set[HI] = event_set[HI] | gate_fall[HI];
      end
    end
  end

  // ADC trigger from pair a only: joined match or upper-a match split
  // Built from the same tick and match as the flag, so the pulse rises
  // on the same edge as the flag; pair b has no path to this output
  assign next_adc = ctrl[0].pair_join_select
                    ? (tick[0] & ({cnt[1], cnt[0]} == {per[1], per[0]}))
                    : (tick[1] & (cnt[1] == per[1]));

  // Count registers; a bus write overrides counting in its cycle
  // Counting resumes from the loaded value on the next tick, so a start
  // value may be loaded while the timer runs
  for (genvar i = 0; i < tcp_pkg::NTMR; i++) begin : g_cnt
    assign cnt_wr[i] = wr_take & (idx == tcp_pkg::IDX_CNT_BASE + 4'(i));

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt[i] <= tcp_pkg::REG_RESET;
      end else if (cnt_wr[i]) begin
        cnt[i] <= lane_merge(cnt[i], wr_word, sel_i[1:0]);
      end else begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // ********************************************
  // Flags and trigger
  // ********************************************
  // Sticky flags, write one to clear; a new event wins over the clear
  // Bits written as zero leave their flag alone, and letting the set win
  // means an event in the clearing cycle is never lost
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_flag <= '0;
    end else if (wr_take && idx == tcp_pkg::IDX_FLAGS && sel_i[0]) begin
      timer_flag <= (timer_flag & ~dat_i[tcp_pkg::NTMR-1:0]) | event_set;
    end else begin
      timer_flag <= timer_flag | event_set;
    end
  end

  // One-cycle trigger pulse, registered
  // Registered so the converter sees a clean strobe free of glitches
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= next_adc;
    end
  end

endmodule : tcp_timer_pairs

// ---- include/tcp_pkg.sv ----
// Package for the cascadable timer pairs: register map, control layout,
// prescale limits and the Wishbone geometry.
// Assumes a 32-bit classic Wishbone bus and a 100 MHz system clock.
package tcp_pkg;

  // ********************************************
  // Bus geometry
  // ********************************************
  localparam int ADR_W  = 8;
  localparam int DAT_W  = 32;
  localparam int REG_W  = 16;
  localparam int NTMR   = 4;
  localparam int NPAIR  = 2;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 5;

  // ********************************************
  // Register indices (word index = byte address / 4)
  // ********************************************
  localparam logic [3:0] IDX_CTRL_BASE = 4'h0;  // Control of timers 0..3
  localparam logic [3:0] IDX_PER_BASE  = 4'h4;  // Period of timers 0..3
  localparam logic [3:0] IDX_CNT_BASE  = 4'h8;  // Count of timers 0..3
  localparam logic [3:0] IDX_FLAGS     = 4'hc;  // Sticky flags, write one to clear

  // ********************************************
  // Control register layout and write masks
  // ********************************************
  typedef struct packed {
    logic       timer_run_enable;
    logic       rsvd14;
    logic       idle_halt;
    logic [5:0] rsvd12_7;
    logic       gated_accumulation_enable;
    logic [1:0] prescale_ratio_field;
    logic       pair_join_select;
    logic       rsvd2;
    logic       clock_source_select;
    logic       rsvd0;
  } tcp_ctrl_t;

  localparam logic [15:0] CTRL_MASK_LOWER = 16'ha07a;
  localparam logic [15:0] CTRL_MASK_UPPER = 16'ha072;
  localparam logic [15:0] REG_RESET       = 16'h0000;

  // ********************************************
  // Prescale terminal counts
  // ********************************************
  localparam logic [1:0] PS_1   = 2'h0;
  localparam logic [1:0] PS_8   = 2'h1;
  localparam logic [1:0] PS_64  = 2'h2;
  localparam logic [1:0] PS_256 = 2'h3;
  localparam logic [7:0] PS_LIM_1   = 8'h00;
  localparam logic [7:0] PS_LIM_8   = 8'h07;
  localparam logic [7:0] PS_LIM_64  = 8'h3f;
  localparam logic [7:0] PS_LIM_256 = 8'hff;

  // ********************************************
  // Clocking
  // ********************************************
  localparam int SYS_CLK_HZ = 100_000_000;

endpackage : tcp_pkg
